// File: logic/odsc_pkg.sv
package odsc_pkg;
	// Frame geometry
	localparam int FRAME_BITS = 32;
	localparam int CMD_HI = 27;
	localparam int CMD_LO = 24;
	localparam int ADDR_HI = 23;
	localparam int ADDR_LO = 20;
	localparam int DATA_HI = 19;
	localparam int DATA_LO = 4;
	localparam int PDM_HI = 9;
	localparam int PDM_LO = 8;
	localparam int CHAN_COUNT = 8;
	// Address meaning all channels
	localparam logic [3:0] ADDR_ALL = 4'hF;
	// Clear codes
	localparam logic [15:0] CLEAR_ZERO = 16'h0000;
	localparam logic [15:0] CLEAR_MID = 16'h8000;
	localparam logic [15:0] CLEAR_FULL = 16'hFFFF;
	// Reset values
	localparam logic [15:0] CODE_RESET = 16'h0000;
	localparam logic [1:0] CLRSEL_RESET = 2'h0;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [1:0] PDM_NORMAL = 2'h0;
	// Which channels are 12-bit (C..F)
	localparam logic [7:0] NARROW_CHANS = 8'h3C;
	// Minimum strobe high time
	localparam int STROBE_HIGH_NS = 15;
	// Commands
	typedef enum logic [3:0] {
		CMD_WRITE_IN = 4'h0,
		CMD_UPDATE = 4'h1,
		CMD_WRITE_ALL = 4'h2,
		CMD_WRITE_UPD = 4'h3,
		CMD_POWER = 4'h4,
		CMD_CLEARSEL = 4'h5,
		CMD_MASK = 4'h6,
		CMD_RESET = 4'h7,
		CMD_REFSET = 4'h8
	} odsc_cmd_t;
endpackage

// File: logic/odsc_frame_if.sv
`timescale 1ns/1ps
`default_nettype none
// Completed frame passed from link domain to core domain
interface odsc_frame_if;
	logic [31:0] word;
	logic toggle;
	modport link (output word, output toggle);
	modport core (input word, input toggle);
endinterface
`default_nettype wire

// File: logic/odsc_link_rx.sv
`timescale 1ns/1ps
`default_nettype none
// Serial receiver on the link clock
module odsc_link_rx
	import odsc_pkg::*;
(
	// Link pins
	input wire logic sclk,
	input wire logic syncN,
	input wire logic sdata,
	// Abort request level, the clear pin inverted in the core
	input wire logic abortReq,
	// Core reset, clears the frame toggle
	input wire logic rst,
	// Frame output
	odsc_frame_if.link frm
);
	logic [31:0] shiftReg; // Incoming bits
	logic [5:0] bitCount; // Bits taken this frame
	logic done; // Frame finished, wait for strobe high
	logic abortA; // Abort synchroniser stage one
	logic abortB; // Abort synchroniser stage two
	logic [31:0] word;
	logic toggle;

	// Abort request crossing
	always_ff @(negedge sclk or posedge syncN) begin
		if (syncN) begin
			abortA <= 1'b0;
			abortB <= 1'b0;
		end else begin
			abortA <= abortReq;
			abortB <= abortA;
		end
	end

	// Shift on falling clock; high strobe clears the frame
	always_ff @(negedge sclk or posedge syncN) begin
		if (syncN) begin
			shiftReg <= 32'h00000000; // RQ16
			bitCount <= 6'h00;
			done <= 1'b0;
		end else if (abortB) begin
			// Clear low spoils the rest of this frame until the strobe rises
			done <= 1'b1; // RQ25
		end else if (!done) begin
			shiftReg <= {shiftReg[30:0], sdata}; // RQ2
			bitCount <= bitCount + 6'h01;
			if (bitCount == 6'(FRAME_BITS - 1)) begin
				done <= 1'b1; // RQ4
			end
		end
	end

	// Publish the word and flip the toggle on the last edge
	always_ff @(negedge sclk or posedge rst) begin
		if (rst) begin
			word <= 32'h00000000;
			toggle <= 1'b0;
		end else if (!syncN && !done && !abortB && bitCount == 6'(FRAME_BITS - 1)) begin
			word <= {shiftReg[30:0], sdata}; // RQ3
			toggle <= ~toggle;
		end
	end

	assign frm.word = word;
	assign frm.toggle = toggle;
endmodule // odsc_link_rx
`default_nettype wire

// File: logic/odsc_core.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// RQ1 - Host starts frame with falling strobe
// RQ2 - Shift one bit per falling clock
// RQ3 - Execute command on 32nd edge
// RQ4 - Strobe may stay low afterwards
// RQ5 - Strobe high 15 ns between frames
// RQ6 - Host may park strobe low
// RQ7 - Frame layout: pad, command, address, data
// RQ8 - Code left aligned, pad bits ignored
// RQ9 - Commands zero to three write/update
// RQ10 - Command four sets power-down
// RQ11 - Commands five, six load clear, mask
// RQ12 - Command seven resets like power-on
// RQ13 - Command eight sets reference enable
// RQ14 - Reserved commands change nothing
// RQ15 - Address selects channel or all
// RQ16 - Early strobe rise discards frame
// RQ17 - Codes are straight binary
// RQ18 - Reference off after power-up
// RQ19 - Channels zero after power-on
// RQ20 - Ignore update and clear during reset
// RQ21 - Internal reference: power-down all channels
// RQ22 - Two-bit power-down mode field
// RQ23 - Data bits select channels H..A
// RQ24 - Clear select picks clear value
// RQ25 - Clear aborts frame, exits next frame
module odsc_core
	import odsc_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Serial link
	input wire logic sclk,
	input wire logic syncN,
	input wire logic sdata,
	// Hardware pins
	input wire logic loadOutputsN,
	input wire logic asyncClearN,
	// Channel outputs, 16 bits each, narrow channels left aligned
	output logic [127:0] outCodes,
	output logic [15:0] powerdownModes,
	output logic referenceOutput,
	output logic clearActive
);
	logic [15:0] inReg [CHAN_COUNT]; // Input registers
	logic [15:0] outReg [CHAN_COUNT]; // Output registers
	logic [1:0] pdMode [CHAN_COUNT]; // Power-down mode per channel
	logic [1:0] clearSel; // Clear code selection
	logic [7:0] hwMask; // Hardware-update mask
	logic refEnable; // Internal reference enable
	logic clearMode; // Clear code in force
	logic [2:0] togSync; // Frame toggle crossing
	logic [1:0] ldSync; // Load pin synchroniser
	logic [1:0] clrSync; // Clear pin synchroniser
	logic clrPrev; // Clear pin history for edge detect
	logic [1:0] rstHold; // Reset in progress filter
	logic frameEvt; // Frame arrived this cycle
	logic clearEvt; // Clear falling edge accepted
	logic [31:0] fw; // Captured frame word
	logic [3:0] cmd;
	logic [3:0] addr;
	logic [15:0] code;
	logic [7:0] sel; // Addressed channels
	logic [15:0] clearValue;
	odsc_frame_if frm();

	// Mask pad bits of narrow channels
	function automatic logic [15:0] trimCode(input logic [15:0] c, input int ch);
		trimCode = NARROW_CHANS[ch] ? {c[15:4], 4'h0} : c; // RQ8
	endfunction

	// Link receiver, aborted while clear is low
	odsc_link_rx rx (
		.sclk(sclk),
		.syncN(syncN),
		.sdata(sdata),
		.abortReq(!asyncClearN), // RQ25
		.rst(rst),
		.frm(frm)
	);

	// Crossings
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			togSync <= 3'h0;
			ldSync <= 2'h3;
			clrSync <= 2'h3;
			clrPrev <= 1'b1;
			rstHold <= 2'h3;
		end else begin
			togSync <= {togSync[1:0], frm.toggle};
			ldSync <= {ldSync[0], loadOutputsN};
			clrSync <= {clrSync[0], asyncClearN};
			clrPrev <= clrSync[1];
			rstHold <= {rstHold[0], 1'b0};
		end
	end

	// Event strobes and frame fields
	assign frameEvt = togSync[2] ^ togSync[1];
	assign clearEvt = clrPrev && !clrSync[1] && (rstHold == 2'h0); // RQ20
	assign fw = frm.word; // Stable for many cycles after toggle
	assign cmd = fw[CMD_HI:CMD_LO]; // RQ7
	assign addr = fw[ADDR_HI:ADDR_LO];
	assign code = fw[DATA_HI:DATA_LO];

	// Address decode
	always_comb begin
		sel = 8'h00;
		if (addr == ADDR_ALL) begin
			sel = 8'hFF; // RQ15
		end else if (addr[3] == 1'b0) begin
			sel[addr[2:0]] = 1'b1;
		end
	end

	// Clear value selection
	always_comb begin
		case (clearSel)
			2'h0: clearValue = CLEAR_ZERO; // RQ24
			2'h1: clearValue = CLEAR_MID;
			2'h2: clearValue = CLEAR_FULL;
			default: clearValue = CLEAR_ZERO;
		endcase
	end

	// Channel registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < CHAN_COUNT; i++) begin
				inReg[i] <= CODE_RESET; // RQ19
				outReg[i] <= CODE_RESET;
			end
		end else if (clearEvt && clearSel != 2'h3) begin
			for (int i = 0; i < CHAN_COUNT; i++) begin
				inReg[i] <= trimCode(clearValue, i);
				outReg[i] <= trimCode(clearValue, i);
			end
		end else if (frameEvt) begin
			for (int i = 0; i < CHAN_COUNT; i++) begin
				case (cmd)
					CMD_WRITE_IN: begin
						if (sel[i]) inReg[i] <= trimCode(code, i); // RQ9
						if (!ldSync[1] && !hwMask[i] && sel[i]) outReg[i] <= trimCode(code, i);
					end
					CMD_UPDATE: begin
						if (sel[i]) outReg[i] <= inReg[i];
					end
					CMD_WRITE_ALL: begin
						if (sel[i]) begin
							inReg[i] <= trimCode(code, i);
							outReg[i] <= trimCode(code, i);
						end else begin
							outReg[i] <= inReg[i];
						end
					end
					CMD_WRITE_UPD: begin
						if (sel[i]) begin
							inReg[i] <= trimCode(code, i);
							outReg[i] <= trimCode(code, i);
						end
					end
					CMD_RESET: begin
						inReg[i] <= CODE_RESET; // RQ12
						outReg[i] <= CODE_RESET;
					end
					default: begin
					end // RQ14
				endcase
			end
		end else if (!ldSync[1] && rstHold == 2'h0) begin
			// Hardware update of unmasked channels
			for (int i = 0; i < CHAN_COUNT; i++) begin
				if (!hwMask[i]) outReg[i] <= inReg[i];
			end
		end
	end

	// Mode and configuration registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < CHAN_COUNT; i++) pdMode[i] <= PDM_NORMAL;
			clearSel <= CLRSEL_RESET;
			hwMask <= MASK_RESET;
			refEnable <= 1'b0; // RQ18
		end else if (frameEvt && !clearEvt) begin
			// A same-cycle clear spoils the frame here, and in the channel registers unless clear select is three
			case (cmd)
				CMD_POWER: begin
					for (int i = 0; i < CHAN_COUNT; i++) begin
						// RQ21 with reference on, all channels take the mode
						if (fw[i] || refEnable) pdMode[i] <= fw[PDM_HI:PDM_LO]; // RQ10 RQ22 RQ23
					end
				end
				CMD_CLEARSEL: clearSel <= fw[1:0]; // RQ11
				CMD_MASK: hwMask <= fw[7:0];
				CMD_RESET: begin
					for (int i = 0; i < CHAN_COUNT; i++) pdMode[i] <= PDM_NORMAL;
					clearSel <= CLRSEL_RESET;
					hwMask <= MASK_RESET;
					refEnable <= 1'b0;
				end
				CMD_REFSET: refEnable <= fw[0]; // RQ13
				default: begin
				end
			endcase
		end
	end

	// Clear mode flag: set by clear, left on next full frame
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			clearMode <= 1'b0;
		end else if (clearEvt) begin
			clearMode <= 1'b1;
		end else if (frameEvt) begin
			clearMode <= 1'b0; // RQ25
		end
	end

	// Output packing, straight binary codes
	always_comb begin
		for (int i = 0; i < CHAN_COUNT; i++) begin
			outCodes[i*16 +: 16] = outReg[i]; // RQ17
			powerdownModes[i*2 +: 2] = pdMode[i];
		end
	end
	// Flags come straight from their registers
	assign referenceOutput = refEnable;
	assign clearActive = clearMode;

	// Soft reset turns the reference off
	AST_REF_RESET: assert property (@(posedge mclk) disable iff (rst) // RQ12
		(frameEvt && !clearEvt && cmd == CMD_RESET) |=> !refEnable)
		else $error("reference not off after reset command");

	// Soft reset brings codes, modes and mask back to power-on values
	AST_SOFT_RESET: assert property (@(posedge mclk) disable iff (rst) // RQ12
		(frameEvt && !clearEvt && cmd == CMD_RESET)
		|=> outCodes == 128'h0 && powerdownModes == 16'h0 && hwMask == MASK_RESET)
		else $error("state not restored by reset command");

	// Reference enable follows the lowest frame bit
	AST_REF_SET: assert property (@(posedge mclk) disable iff (rst) // RQ13
		(frameEvt && !clearEvt && cmd == CMD_REFSET) |=> refEnable == $past(fw[0]))
		else $error("reference enable mismatch");

	// Mask command loads the hardware-update mask
	AST_MASK: assert property (@(posedge mclk) disable iff (rst) // RQ11
		(frameEvt && !clearEvt && cmd == CMD_MASK) |=> hwMask == $past(fw[7:0]))
		else $error("mask not loaded");

	// Clear select command loads the selection
	AST_CLEAR_SEL: assert property (@(posedge mclk) disable iff (rst) // RQ11
		(frameEvt && !clearEvt && cmd == CMD_CLEARSEL) |=> clearSel == $past(fw[1:0]))
		else $error("clear select not loaded");

	// Reserved commands leave codes, modes, mask, clear select and reference alone
	AST_RESERVED: assert property (@(posedge mclk) disable iff (rst) // RQ14
		(frameEvt && !clearEvt && cmd[3] && cmd[2:0] != 3'h0)
		|=> $stable(outCodes) && $stable(powerdownModes) && $stable(hwMask)
			&& $stable(clearSel) && $stable(refEnable))
		else $error("reserved command changed state");

	// Clear edge enters clear mode
	AST_CLEAR_MODE: assert property (@(posedge mclk) disable iff (rst) // RQ25
		clearEvt |=> clearMode)
		else $error("clear mode not entered");

	// A complete frame leaves clear mode
	AST_FRAME_EXIT: assert property (@(posedge mclk) disable iff (rst) // RQ25
		(frameEvt && !clearEvt) |=> !clearMode)
		else $error("clear mode not left by frame");

	// Clear edge loads the selected clear value
	AST_CLEAR_LOAD: assert property (@(posedge mclk) disable iff (rst) // RQ24
		(clearEvt && clearSel != 2'h3) |=> outReg[0] == $past(clearValue))
		else $error("clear value not loaded");

	// Clear select three leaves the codes alone
	AST_CLEAR_NOP: assert property (@(posedge mclk) disable iff (rst) // RQ24
		(clearEvt && clearSel == 2'h3 && !frameEvt && ldSync[1]) |=> $stable(outCodes))
		else $error("no-op clear changed codes");

	// Direct write lands in the addressed output
	AST_WRITE_UPD: assert property (@(posedge mclk) disable iff (rst) // RQ9
		(frameEvt && !clearEvt && cmd == CMD_WRITE_UPD && addr == 4'h0)
		|=> outReg[0] == $past(code))
		else $error("direct write failed");

	// Address all reaches the last channel too
	AST_ADDR_ALL: assert property (@(posedge mclk) disable iff (rst) // RQ15
		(frameEvt && !clearEvt && cmd == CMD_WRITE_UPD && addr == ADDR_ALL)
		|=> outCodes[127:112] == $past(code))
		else $error("all-channel write missed the last channel");

	// Write-input with the load pin high leaves the outputs alone
	AST_WRITE_IN: assert property (@(posedge mclk) disable iff (rst) // RQ9
		(frameEvt && !clearEvt && cmd == CMD_WRITE_IN && ldSync[1])
		|=> $stable(outCodes))
		else $error("write to input register moved an output");

	// Update command copies the input register
	AST_UPDATE: assert property (@(posedge mclk) disable iff (rst) // RQ9
		(frameEvt && !clearEvt && cmd == CMD_UPDATE && addr == 4'h0)
		|=> outReg[0] == $past(inReg[0]))
		else $error("update did not copy input register");

	// Write-all writes its channel and updates the others from their inputs
	AST_WRITE_ALL: assert property (@(posedge mclk) disable iff (rst) // RQ9
		(frameEvt && !clearEvt && cmd == CMD_WRITE_ALL && addr == 4'h5)
		|=> outCodes[95:84] == $past(code[15:4]) && outReg[0] == $past(inReg[0]))
		else $error("write with update all failed");

	// Power-down mode reaches a selected channel
	AST_POWER: assert property (@(posedge mclk) disable iff (rst) // RQ22 RQ23
		(frameEvt && !clearEvt && cmd == CMD_POWER && fw[0])
		|=> powerdownModes[1:0] == $past(fw[PDM_HI:PDM_LO]))
		else $error("power-down mode not taken");

	// With the reference on, power-down takes all channels
	AST_POWER_ALL: assert property (@(posedge mclk) disable iff (rst) // RQ21
		(frameEvt && !clearEvt && cmd == CMD_POWER && refEnable)
		|=> powerdownModes == {8{$past(fw[PDM_HI:PDM_LO])}})
		else $error("power-down not applied to all channels");

	// Narrow channels keep their pad bits zero
	AST_NARROW: assert property (@(posedge mclk) disable iff (rst) // RQ8
		(outCodes[35:32] | outCodes[51:48] | outCodes[67:64] | outCodes[83:80]) == 4'h0)
		else $error("narrow channel pad bits set");

	// Load pin copies inputs to unmasked outputs
	AST_HW_UPDATE: assert property (@(posedge mclk) disable iff (rst) // RQ11
		(!ldSync[1] && rstHold == 2'h0 && !frameEvt && !clearEvt && !hwMask[1])
		|=> outReg[1] == $past(inReg[1]))
		else $error("load pin did not update channel");

	// Pins stay ignored while reset settles
	AST_CLR_IGN: assert property (@(posedge mclk) disable iff (rst) // RQ20
		(rstHold != 2'h0 && !frameEvt) |=> $stable(outCodes) && $stable(clearMode))
		else $error("pin acted during reset");

	// A frame is executed once
	AST_ONE_EVT: assert property (@(posedge mclk) disable iff (rst) // RQ3
		frameEvt |=> !frameEvt)
		else $error("frame executed twice");

	// Main scenarios
	CVR_FRAME: cover property (@(posedge mclk) disable iff (rst) frameEvt);
	CVR_CLEAR: cover property (@(posedge mclk) disable iff (rst) clearEvt);
	CVR_POWER: cover property (@(posedge mclk) disable iff (rst) frameEvt && cmd == CMD_POWER);
	CVR_LOAD: cover property (@(posedge mclk) disable iff (rst) !ldSync[1] && rstHold == 2'h0);
	CVR_REF_ALL: cover property (@(posedge mclk) disable iff (rst)
		frameEvt && cmd == CMD_POWER && refEnable);
endmodule // odsc_core
`default_nettype wire

// File: tb/odsc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Serial master: the link clock runs only inside frames and rests high between them
module odsc_host_model (
	// Link pins
	output logic sclk,
	output logic syncN,
	output logic sdata
);
	// Idle link at time zero
	initial begin
		sclk = 1'b1;
		syncN = 1'b1;
		sdata = 1'b0;
	end
	// Send nbits of word MSB first; fewer than 32 bits aborts the frame
	task automatic send(input logic [31:0] word, input int nbits, input bit park);
		int i;
		// Strobe high long enough before the new falling edge
		syncN <= 1'b1;
		#20;
		syncN <= 1'b0;
		// Data changes while the clock is high, the device samples on the fall
		for (i = 31; i >= 32 - nbits; i--) begin
			sdata <= word[i];
			#7.5 sclk <= 1'b0;
			#7.5 sclk <= 1'b1;
		end
		// Released data line shows the inverse of its last bit
		sdata <= ~sdata;
		#7.5;
		// Parking low between frames saves power
		if (!park) begin
			syncN <= 1'b1;
		end
	endtask
endmodule // odsc_host_model
`default_nettype wire

// File: tb/octal_dac_serial_command_unit_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Bench: host model drives frames, a reference model predicts every output
module octal_dac_serial_command_unit_tb_top;
	import odsc_pkg::*;
	logic mclk = 1'b0; // Core clock
	logic rst = 1'b1; // Reset
	logic loadOutputsN = 1'b1; // Load pin
	logic asyncClearN = 1'b1; // Clear pin
	logic sclk, syncN, sdata; // Link pins from host
	logic [127:0] outCodes;
	logic [15:0] powerdownModes;
	logic referenceOutput, clearActive;
	int n_fail = 0;
	int check_count = 0;
	// Reference model state
	int inReg[8], outReg[8], pdm[8];
	int mask, clrSel, refOn, clrOn;
	// 125 MHz clock
	always #4 mclk = ~mclk;
	odsc_host_model u_host (.sclk(sclk), .syncN(syncN), .sdata(sdata));
	odsc_core u_dut (.mclk(mclk), .rst(rst), .sclk(sclk), .syncN(syncN), .sdata(sdata),
		.loadOutputsN(loadOutputsN), .asyncClearN(asyncClearN), .outCodes(outCodes),
		.powerdownModes(powerdownModes), .referenceOutput(referenceOutput),
		.clearActive(clearActive));
	// Narrow channels keep only the top 12 bits
	function automatic int maskOf(int ch);
		return NARROW_CHANS[ch] ? 32'hFFF0 : 32'hFFFF;
	endfunction
	// Apply one complete frame to the model
	task automatic exec(input logic [31:0] w);
		int cmd, adr, code, ch;
		cmd = w[27:24];
		adr = w[23:20];
		code = w[19:4];
		clrOn = 0;
		for (ch = 0; ch < 8; ch++) begin
			if (adr == 15 || adr == ch) begin
				if (cmd == 0 || cmd == 2 || cmd == 3) inReg[ch] = code & maskOf(ch);
				if (cmd == 1 || cmd == 3) outReg[ch] = inReg[ch];
			end
			if (cmd == 2) outReg[ch] = inReg[ch];
			if (cmd == 4 && (w[ch] || refOn != 0)) pdm[ch] = w[9:8];
			if (cmd == 7) begin
				inReg[ch] = 0;
				outReg[ch] = 0;
				pdm[ch] = 0;
			end
		end
		if (cmd == 5) clrSel = w[1:0];
		if (cmd == 6) mask = w[7:0];
		if (cmd == 7) begin
			clrSel = 0;
			mask = 0;
			refOn = 0;
		end
		if (cmd == 8) refOn = w[0];
	endtask
	// Compare one value
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask
	// Let the result land, then compare every output
	task automatic check_all();
		int ch;
		repeat (8) @(posedge mclk);
		#1;
		for (ch = 0; ch < 8; ch++) begin
			cmp(outCodes[16*ch +: 16], 16'(outReg[ch]), "code");
			cmp({14'h0, powerdownModes[2*ch +: 2]}, 16'(pdm[ch]), "mode");
		end
		cmp({15'h0, referenceOutput}, 16'(refOn), "ref");
		cmp({15'h0, clearActive}, 16'(clrOn), "clear");
	endtask
	// Full frame then compare
	task automatic frame(input logic [31:0] w, input bit park);
		u_host.send(w, 32, park);
		exec(w);
		check_all();
	endtask
	// Pulse the load or clear pin low for a few cycles
	task automatic pulse_pin(input bit isClear);
		int ch;
		@(posedge mclk);
		if (isClear) asyncClearN <= 1'b0;
		else loadOutputsN <= 1'b0;
		repeat (4) @(posedge mclk);
		asyncClearN <= 1'b1;
		loadOutputsN <= 1'b1;
		for (ch = 0; ch < 8; ch++) begin
			// Clear select three leaves the codes alone
			if (isClear && clrSel != 3) begin
				inReg[ch] = (clrSel == 1 ? 32'h8000 : clrSel == 2 ? 32'hFFFF : 0) & maskOf(ch);
				outReg[ch] = inReg[ch];
			end else if (!isClear && !mask[ch]) outReg[ch] = inReg[ch];
		end
		if (isClear) clrOn = 1;
		check_all();
	endtask
	// Verdict and end of run
	task automatic complete_run();
		if (n_fail == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Hang guard
	initial begin
		#200000;
		n_fail++;
		complete_run();
	end
	// Main sequence
	initial begin
		int i;
		void'($urandom(32'h1941a01b));
		// Clear pin toggles while reset holds
		@(posedge mclk) asyncClearN <= 1'b0;
		@(posedge mclk) asyncClearN <= 1'b1;
		rst <= 1'b0;
		check_all();
		for (i = 0; i < 8; i++) frame({8'hA3, 4'(i), 16'($urandom), 4'h5}, i[0]);
		frame({8'h00, 4'h0, 16'($urandom), 4'h0}, 1'b0);
		frame({8'h01, 4'h0, 20'h0}, 1'b0);
		frame({8'h02, 4'h5, 16'($urandom), 4'h0}, 1'b0);
		frame({8'h03, 4'hF, 16'($urandom), 4'h0}, 1'b0);
		u_host.send({8'h03, 4'hF, 16'($urandom), 4'h0}, 20, 1'b0);
		check_all();
		for (i = 9; i < 16; i++) frame({4'h0, 4'(i), 4'hF, 20'($urandom)}, 1'b0);
		frame({8'h06, 4'h0, 12'h0, 8'hA5}, 1'b0);
		frame({8'h00, 4'hF, 16'($urandom), 4'h0}, 1'b0);
		pulse_pin(1'b0);
		for (i = 0; i < 4; i++) frame({8'h04, 4'h0, 10'h0, 2'(i), 8'($urandom)}, 1'b0);
		frame({8'h08, 4'h0, 20'h1}, 1'b0);
		frame({8'h04, 4'h0, 10'h0, 2'h2, 8'h01}, 1'b0);
		frame({8'h08, 24'h0}, 1'b0);
		frame({8'h05, 4'h0, 20'h3}, 1'b0);
		pulse_pin(1'b1);
		frame({8'h05, 4'h0, 20'h1}, 1'b0);
		pulse_pin(1'b1);
		frame({8'h03, 4'h6, 16'($urandom), 4'h0}, 1'b0);
		// Clear falling in mid-frame loads the clear code and spoils the frame
		fork
			u_host.send({8'h03, 4'hF, 16'($urandom), 4'h0}, 32, 1'b0);
			begin
				repeat (20) @(posedge mclk);
				pulse_pin(1'b1);
			end
		join
		check_all();
		frame({8'h07, 24'h0}, 1'b0);
		complete_run();
	end
endmodule // octal_dac_serial_command_unit_tb_top
`default_nettype wire
